// ==== verilog/flag_ops_pkg.sv ====
// Constants, op codes and carriers for the status flag and bit instruction unit
// ****************************************************************************
// Function
// RULE1 - Indexed flag clear forces the selected status bit to zero, others kept.
// RULE2 - Indexed flag raise forces the selected status bit to one, others kept.
// RULE3 - Bit-to-transfer copies the chosen register bit into the transfer flag only.
// RULE4 - Transfer-to-bit writes transfer flag into chosen register bit, flags untouched.
// RULE5 - Carry raise sets carry to one, nothing else changes.
// RULE6 - Carry drop sets carry to zero, nothing else changes.
// RULE7 - Negative raise sets negative flag to one, nothing else changes.
// RULE8 - Negative drop sets negative flag to zero, nothing else changes.
// RULE9 - Zero raise sets zero flag to one, nothing else changes.
// RULE10 - Zero drop sets zero flag to zero, nothing else changes.
// RULE11 - Interrupt enable op sets global interrupt enable to one.
// RULE12 - Interrupt disable op sets global interrupt enable to zero.
// RULE13 - Signed raise sets signed test flag to one, nothing else changes.
// RULE14 - Signed drop sets signed test flag to zero, nothing else changes.
// RULE15 - Overflow raise sets overflow flag to one, nothing else changes.
// RULE16 - Overflow drop sets overflow flag to zero, nothing else changes.
// RULE17 - Transfer raise sets transfer flag to one, nothing else changes.
// RULE18 - Every such instruction completes in one clock, visible to the next.
// ****************************************************************************
package flag_ops_pkg;

  // ****************************************************************************
  // Widths and flag positions
  // ****************************************************************************
  localparam int          DATA_W        = 8;
  localparam int          BIT_IDX_W     = 3;
  localparam int          REG_IDX_W     = 5;
  localparam int          NUM_WORK_REGS = 32;
  localparam int          WB_ADDR_W     = 8;
  localparam int          WB_DATA_W     = 32;
  localparam logic [2:0]  FLAG_CARRY    = 3'h0;
  localparam logic [2:0]  FLAG_ZERO     = 3'h1;
  localparam logic [2:0]  FLAG_NEG      = 3'h2;
  localparam logic [2:0]  FLAG_OVF      = 3'h3;
  localparam logic [2:0]  FLAG_SIGNED   = 3'h4;
  localparam logic [2:0]  FLAG_TRANSFER = 3'h6;
  localparam logic [2:0]  FLAG_IRQ_EN   = 3'h7;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [7:0]  REG_RESET     = 8'h00;

  // ****************************************************************************
  // Register map and command word fields
  // ****************************************************************************
  localparam logic [7:0]  ADDR_STATUS   = 8'h00;
  localparam logic [7:0]  ADDR_COMMAND  = 8'h04;
  localparam logic [7:0]  ADDR_REG_BASE = 8'h80;
  localparam int          CMD_CODE_LSB  = 0;
  localparam int          CMD_BIT_LSB   = 8;
  localparam int          CMD_REG_LSB   = 16;

  // ****************************************************************************
  // Op codes and carriers
  // ****************************************************************************
  typedef enum logic [4:0] {
    OP_NONE                 = 5'h00,
    OP_INDEXED_FLAG_CLEAR   = 5'h01,
    OP_INDEXED_FLAG_RAISE   = 5'h02,
    OP_BIT_TO_TRANSFER_FLAG = 5'h03,
    OP_TRANSFER_FLAG_TO_BIT = 5'h04,
    OP_CARRY_RAISE          = 5'h05,
    OP_CARRY_DROP           = 5'h06,
    OP_NEGATIVE_RAISE       = 5'h07,
    OP_NEGATIVE_DROP        = 5'h08,
    OP_ZERO_RAISE           = 5'h09,
    OP_ZERO_DROP            = 5'h0A,
    OP_INTERRUPT_ENABLE     = 5'h0B,
    OP_INTERRUPT_DISABLE    = 5'h0C,
    OP_SIGNED_RAISE         = 5'h0D,
    OP_SIGNED_DROP          = 5'h0E,
    OP_OVERFLOW_RAISE       = 5'h0F,
    OP_OVERFLOW_DROP        = 5'h10,
    OP_TRANSFER_RAISE       = 5'h11
  } op_e;

  typedef struct packed {
    op_e                    code;
    logic [BIT_IDX_W-1:0]   bit_sel;
    logic [REG_IDX_W-1:0]   reg_idx;
  } op_s;

  typedef struct packed {
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [WB_ADDR_W-1:0]   adr;
    logic [3:0]             sel;
    logic [WB_DATA_W-1:0]   dat;
  } wb_req_s;

endpackage

// ==== verilog/status_flag_bit_ops.sv ====
// Status flag and bit instruction execution unit with a Wishbone register slave
module status_flag_bit_ops
  import flag_ops_pkg::*;
#(
  parameter int NUM_REGS = NUM_WORK_REGS
)
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 op_valid_i,
  input  wire op_s                  op_i,
  input  wire wb_req_s              wb_i,
  output logic [WB_DATA_W-1:0]      wb_dat_o,
  output logic                      wb_ack_o,
  output logic [DATA_W-1:0]         status_flags_o,
  output logic                      irq_enable_o,
  output logic                      exec_done_o
);

  // ****************************************************************************
  // Storage and decode signals
  // ****************************************************************************
  logic [DATA_W-1:0]    status_flags;
  logic [DATA_W-1:0]    next_status;
  logic [DATA_W-1:0]    reg_file [NUM_REGS];
  logic                 bus_go;
  logic                 bus_wr;
  logic                 hit_status;
  logic                 hit_command;
  logic                 hit_reg;
  logic [REG_IDX_W-1:0] bus_reg_idx;
  logic                 bus_cmd_wr;
  logic                 exec_valid;
  op_s                  exec_op;
  op_s                  bus_op;
  logic                 src_bit;
  logic [WB_DATA_W-1:0] next_rdata;

  // ****************************************************************************
  // Wishbone decode
  // ****************************************************************************
  // Decoder ops win the cycle; the bus waits so both never write the same state
  assign bus_go      = wb_i.cyc && wb_i.stb && !wb_ack_o && !op_valid_i;
  assign bus_wr      = bus_go && wb_i.we && wb_i.sel[0];
  assign hit_status  = (wb_i.adr == ADDR_STATUS);
  assign hit_command = (wb_i.adr == ADDR_COMMAND);
  assign hit_reg     = (wb_i.adr >= ADDR_REG_BASE) && (wb_i.adr[1:0] == 2'h0)
                       && (32'(wb_i.adr[WB_ADDR_W-1:2] - ADDR_REG_BASE[WB_ADDR_W-1:2]) < NUM_REGS);
  assign bus_reg_idx = REG_IDX_W'(wb_i.adr[WB_ADDR_W-1:2] - ADDR_REG_BASE[WB_ADDR_W-1:2]);
  assign bus_cmd_wr  = bus_wr && hit_command;

  assign bus_op.code    = op_e'(wb_i.dat[CMD_CODE_LSB +: 5]);
  assign bus_op.bit_sel = wb_i.dat[CMD_BIT_LSB +: BIT_IDX_W];
  assign bus_op.reg_idx = wb_i.dat[CMD_REG_LSB +: REG_IDX_W];

  // ****************************************************************************
  // Instruction select
  // ****************************************************************************
  assign exec_valid = op_valid_i || bus_cmd_wr;
  assign exec_op    = op_valid_i ? op_i : bus_op;
  assign src_bit    = reg_file[exec_op.reg_idx][exec_op.bit_sel];

  // ****************************************************************************
  // Status flag update
  // ****************************************************************************
  always_comb
  begin
    next_status = status_flags;
    if (exec_valid)
    begin
      case (exec_op.code)
        OP_INDEXED_FLAG_CLEAR:   next_status[exec_op.bit_sel] = 1'b0;   // [RULE1]
        OP_INDEXED_FLAG_RAISE:   next_status[exec_op.bit_sel] = 1'b1;   // [RULE2]
        OP_BIT_TO_TRANSFER_FLAG: next_status[FLAG_TRANSFER]   = src_bit; // [RULE3]
        OP_CARRY_RAISE:          next_status[FLAG_CARRY]      = 1'b1;   // [RULE5]
        OP_CARRY_DROP:           next_status[FLAG_CARRY]      = 1'b0;   // [RULE6]
        OP_NEGATIVE_RAISE:       next_status[FLAG_NEG]        = 1'b1;   // [RULE7]
        OP_NEGATIVE_DROP:        next_status[FLAG_NEG]        = 1'b0;   // [RULE8]
        OP_ZERO_RAISE:           next_status[FLAG_ZERO]       = 1'b1;   // [RULE9]
        OP_ZERO_DROP:            next_status[FLAG_ZERO]       = 1'b0;   // [RULE10]
        OP_INTERRUPT_ENABLE:     next_status[FLAG_IRQ_EN]     = 1'b1;   // [RULE11]
        OP_INTERRUPT_DISABLE:    next_status[FLAG_IRQ_EN]     = 1'b0;   // [RULE12]
        OP_SIGNED_RAISE:         next_status[FLAG_SIGNED]     = 1'b1;   // [RULE13]
        OP_SIGNED_DROP:          next_status[FLAG_SIGNED]     = 1'b0;   // [RULE14]
        OP_OVERFLOW_RAISE:       next_status[FLAG_OVF]        = 1'b1;   // [RULE15]
        OP_OVERFLOW_DROP:        next_status[FLAG_OVF]        = 1'b0;   // [RULE16]
        OP_TRANSFER_RAISE:       next_status[FLAG_TRANSFER]   = 1'b1;   // [RULE17]
        default:                 next_status = status_flags;  // Bit load and unknown codes
      endcase
    end
    else if (bus_wr && hit_status)
    begin
      next_status = wb_i.dat[DATA_W-1:0];
    end
  end

  // Single registered stage so the next op already sees the result
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_flags <= STATUS_RESET;
    else
      status_flags <= next_status;  // [RULE18]
  end

  // ****************************************************************************
  // Working register file
  // ****************************************************************************
  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_reg
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        reg_file[g] <= REG_RESET;
      else if (exec_valid && exec_op.code == OP_TRANSFER_FLAG_TO_BIT && exec_op.reg_idx == REG_IDX_W'(g))
        reg_file[g][exec_op.bit_sel] <= status_flags[FLAG_TRANSFER];  // [RULE4]
      else if (bus_wr && hit_reg && bus_reg_idx == REG_IDX_W'(g))
        reg_file[g] <= wb_i.dat[DATA_W-1:0];
    end
  end

  // ****************************************************************************
  // Bus answer
  // ****************************************************************************
  always_comb
  begin
    next_rdata = '0;
    if (hit_status)
      next_rdata[DATA_W-1:0] = status_flags;
    else if (hit_reg)
      next_rdata[DATA_W-1:0] = reg_file[bus_reg_idx];
  end

  // Unmapped addresses still ack, reading zero, so a stray access never hangs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= bus_go;
      if (bus_go && !wb_i.we)
        wb_dat_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      exec_done_o <= 1'b0;
    else
      exec_done_o <= exec_valid;  // [RULE18]
  end

  assign status_flags_o = status_flags;
  assign irq_enable_o   = status_flags[FLAG_IRQ_EN];

  // ****************************************************************************
  // Assertions
  // ****************************************************************************
  function automatic logic others_kept(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                       input logic [2:0] idx);
    logic [DATA_W-1:0] diff;
    diff = (a ^ b) & ~(DATA_W'(1) << idx);
    return (diff == '0);
  endfunction

  property p_flag_clear;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_INDEXED_FLAG_CLEAR) |=>
      !status_flags[$past(exec_op.bit_sel)] && others_kept(status_flags, $past(status_flags), $past(exec_op.bit_sel));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("indexed clear wrong"); // [RULE1]

  property p_flag_raise;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_INDEXED_FLAG_RAISE) |=>
      status_flags[$past(exec_op.bit_sel)] && others_kept(status_flags, $past(status_flags), $past(exec_op.bit_sel));
  endproperty
  a_flag_raise: assert property (p_flag_raise) else $error("indexed raise wrong"); // [RULE2]

  property p_bit_to_transfer;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_BIT_TO_TRANSFER_FLAG) |=>
      status_flags[FLAG_TRANSFER] == $past(src_bit) && others_kept(status_flags, $past(status_flags), FLAG_TRANSFER);
  endproperty
  a_bit_to_transfer: assert property (p_bit_to_transfer) else $error("bit store wrong"); // [RULE3]

  property p_transfer_to_bit;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_TRANSFER_FLAG_TO_BIT) |=>
      reg_file[$past(exec_op.reg_idx)][$past(exec_op.bit_sel)] == $past(status_flags[FLAG_TRANSFER])
      && $stable(status_flags);
  endproperty
  a_transfer_to_bit: assert property (p_transfer_to_bit) else $error("bit load wrong"); // [RULE4]

  property p_carry_raise;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_CARRY_RAISE) |=>
      status_flags[FLAG_CARRY] && others_kept(status_flags, $past(status_flags), FLAG_CARRY);
  endproperty
  a_carry_raise: assert property (p_carry_raise) else $error("carry raise wrong"); // [RULE5]

  property p_carry_drop;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_CARRY_DROP) |=>
      !status_flags[FLAG_CARRY] && others_kept(status_flags, $past(status_flags), FLAG_CARRY);
  endproperty
  a_carry_drop: assert property (p_carry_drop) else $error("carry drop wrong"); // [RULE6]

  property p_negative_raise;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_NEGATIVE_RAISE) |=>
      status_flags[FLAG_NEG] && others_kept(status_flags, $past(status_flags), FLAG_NEG);
  endproperty
  a_negative_raise: assert property (p_negative_raise) else $error("negative raise wrong"); // [RULE7]

  property p_negative_drop;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_NEGATIVE_DROP) |=>
      !status_flags[FLAG_NEG] && others_kept(status_flags, $past(status_flags), FLAG_NEG);
  endproperty
  a_negative_drop: assert property (p_negative_drop) else $error("negative drop wrong"); // [RULE8]

  property p_zero_raise;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_ZERO_RAISE) |=>
      status_flags[FLAG_ZERO] && others_kept(status_flags, $past(status_flags), FLAG_ZERO);
  endproperty
  a_zero_raise: assert property (p_zero_raise) else $error("zero raise wrong"); // [RULE9]

  property p_zero_drop;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_ZERO_DROP) |=>
      !status_flags[FLAG_ZERO] && others_kept(status_flags, $past(status_flags), FLAG_ZERO);
  endproperty
  a_zero_drop: assert property (p_zero_drop) else $error("zero drop wrong"); // [RULE10]

  property p_irq_enable;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_INTERRUPT_ENABLE) |=>
      irq_enable_o && others_kept(status_flags, $past(status_flags), FLAG_IRQ_EN);
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("interrupt enable wrong"); // [RULE11]

  property p_irq_disable;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_INTERRUPT_DISABLE) |=>
      !irq_enable_o && others_kept(status_flags, $past(status_flags), FLAG_IRQ_EN);
  endproperty
  a_irq_disable: assert property (p_irq_disable) else $error("interrupt disable wrong"); // [RULE12]

  property p_signed_raise;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_SIGNED_RAISE) |=>
      status_flags[FLAG_SIGNED] && others_kept(status_flags, $past(status_flags), FLAG_SIGNED);
  endproperty
  a_signed_raise: assert property (p_signed_raise) else $error("signed raise wrong"); // [RULE13]

  property p_signed_drop;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_SIGNED_DROP) |=>
      !status_flags[FLAG_SIGNED] && others_kept(status_flags, $past(status_flags), FLAG_SIGNED);
  endproperty
  a_signed_drop: assert property (p_signed_drop) else $error("signed drop wrong"); // [RULE14]

  property p_overflow_raise;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_OVERFLOW_RAISE) |=>
      status_flags[FLAG_OVF] && others_kept(status_flags, $past(status_flags), FLAG_OVF);
  endproperty
  a_overflow_raise: assert property (p_overflow_raise) else $error("overflow raise wrong"); // [RULE15]

  property p_overflow_drop;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_OVERFLOW_DROP) |=>
      !status_flags[FLAG_OVF] && others_kept(status_flags, $past(status_flags), FLAG_OVF);
  endproperty
  a_overflow_drop: assert property (p_overflow_drop) else $error("overflow drop wrong"); // [RULE16]

  property p_transfer_raise;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_TRANSFER_RAISE) |=>
      status_flags[FLAG_TRANSFER] && others_kept(status_flags, $past(status_flags), FLAG_TRANSFER);
  endproperty
  a_transfer_raise: assert property (p_transfer_raise) else $error("transfer raise wrong"); // [RULE17]

  property p_one_cycle;
    @(posedge clk_i) disable iff (rst_i)
    exec_valid |=> exec_done_o && status_flags == $past(next_status);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("op not done in one cycle"); // [RULE18]

  property p_load_keeps_others;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && exec_op.code == OP_TRANSFER_FLAG_TO_BIT) |=>
      others_kept(reg_file[$past(exec_op.reg_idx)], $past(reg_file[exec_op.reg_idx]), $past(exec_op.bit_sel));
  endproperty
  a_load_keeps_others: assert property (p_load_keeps_others) else $error("bit load touched other bits"); // [RULE4]

  property p_refused_keeps;
    @(posedge clk_i) disable iff (rst_i)
    (exec_valid && (exec_op.code == OP_NONE || exec_op.code > OP_TRANSFER_RAISE)) |=> $stable(status_flags);
  endproperty
  a_refused_keeps: assert property (p_refused_keeps) else $error("unknown op changed flags");

  property p_done_only_after_op;
    @(posedge clk_i) disable iff (rst_i)
    !exec_valid |=> !exec_done_o;
  endproperty
  a_done_only_after_op: assert property (p_done_only_after_op) else $error("done without an op"); // [RULE18]

  property p_bus_status_write;
    @(posedge clk_i) disable iff (rst_i)
    (bus_wr && hit_status) |=> status_flags == $past(wb_i.dat[DATA_W-1:0]);
  endproperty
  a_bus_status_write: assert property (p_bus_status_write) else $error("status write lost");

  property p_bus_reg_write;
    @(posedge clk_i) disable iff (rst_i)
    (bus_wr && hit_reg) |=> reg_file[$past(bus_reg_idx)] == $past(wb_i.dat[DATA_W-1:0]);
  endproperty
  a_bus_reg_write: assert property (p_bus_reg_write) else $error("register write lost");

  property p_status_read;
    @(posedge clk_i) disable iff (rst_i)
    (bus_go && !wb_i.we && hit_status) |=> wb_ack_o && wb_dat_o == WB_DATA_W'($past(status_flags));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read data wrong");

  // Decoder ops own the cycle, so a pending bus access must not be answered
  property p_op_stalls_bus;
    @(posedge clk_i) disable iff (rst_i)
    op_valid_i |=> !wb_ack_o;
  endproperty
  a_op_stalls_bus: assert property (p_op_stalls_bus) else $error("bus answered during an op");

  property p_ack_has_request;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_i.cyc && wb_i.stb);
  endproperty
  a_ack_has_request: assert property (p_ack_has_request) else $error("ack without a request");

  property p_bus_ack;
    @(posedge clk_i) disable iff (rst_i)
    (wb_i.cyc && wb_i.stb && !wb_ack_o && !op_valid_i) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus ack not a single cycle pulse");

endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the status flag and bit instruction unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flag_ops_pkg::*;

  // ****************************************************************************
  // Signals and instance
  // ****************************************************************************
  logic                 clk_i;
  logic                 rst_i;
  logic                 op_valid_i;
  op_s                  op_i;
  wb_req_s              wb_i;
  logic [WB_DATA_W-1:0] wb_dat_o;
  logic                 wb_ack_o;
  logic [DATA_W-1:0]    status_flags_o;
  logic                 irq_enable_o;
  logic                 exec_done_o;
  int                   n_mismatch;
  int                   checks;
  logic [31:0]          rd;

  status_flag_bit_ops u_status_flag_bit_ops (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .op_valid_i     (op_valid_i),
    .op_i           (op_i),
    .wb_i           (wb_i),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .status_flags_o (status_flags_o),
    .irq_enable_o   (irq_enable_o),
    .exec_done_o    (exec_done_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ****************************************************************************
  // Shared tasks
  // ****************************************************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Classic cycle; waits as long as the slave needs, only the watchdog ends a hang
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         input logic [3:0] sel, output logic [31:0] rdat);
    int n;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_i <= '0;
    cmp(n, 32'h2, "bus ack latency");
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [31:0] unused;
    wb_xfer(1'b1, adr, {24'h0, d}, 4'hF, unused);
  endtask

  // One op through the decoder port; returns at the second falling edge after the taking edge
  task automatic do_op(input op_e c, input logic [2:0] b, input logic [4:0] r);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i       <= '{code: c, bit_sel: b, reg_idx: r};
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    @(negedge clk_i);
    cmp({31'h0, exec_done_o}, 32'h1, "done pulse");
    @(negedge clk_i);
    cmp({31'h0, exec_done_o}, 32'h0, "done pulse length");
  endtask

  // ****************************************************************************
  // Scenarios
  // ****************************************************************************
  task automatic t_reset;
    cmp({24'h0, status_flags_o}, {24'h0, STATUS_RESET}, "status after reset");
    cmp({31'h0, irq_enable_o}, 32'h0, "irq enable after reset");
    wb_xfer(1'b0, ADDR_REG_BASE + 8'h7C, 32'h0, 4'hF, rd);
    cmp(rd, {24'h0, REG_RESET}, "work reg after reset");
    wb_xfer(1'b1, 8'h40, 32'hFF, 4'hF, rd);
    wb_xfer(1'b0, 8'h40, 32'h0, 4'hF, rd);
    cmp(rd, 32'h0, "unmapped read");
    wb_xfer(1'b1, ADDR_STATUS, 32'hFF, 4'h0, rd);
    @(negedge clk_i);
    cmp({24'h0, status_flags_o}, 32'h0, "write without byte select");
  endtask

  task automatic t_flag_ops;
    logic [2:0] pos [6];
    logic [7:0] base;
    logic [7:0] exp;
    int         k;
    pos = '{FLAG_CARRY, FLAG_NEG, FLAG_ZERO, FLAG_IRQ_EN, FLAG_SIGNED, FLAG_OVF};
    for (k = 5; k <= 17; k++)
    begin
      base = (k % 2 == 1) ? 8'h00 : 8'hFF;
      exp  = base;
      if (k == 17)
        exp[FLAG_TRANSFER] = 1'b1;
      else
        exp[pos[(k - 5) / 2]] = (k % 2 == 1);
      wr(ADDR_STATUS, base);
      do_op(op_e'(k), 3'h0, 5'h00);
      cmp({24'h0, status_flags_o}, {24'h0, exp}, "dedicated flag op");
      cmp({31'h0, irq_enable_o}, {31'h0, exp[FLAG_IRQ_EN]}, "irq enable");
    end
  endtask

  // Back to back, one per cycle, each must see the previous result
  task automatic t_indexed(input op_e c, input logic [7:0] base);
    logic [7:0] exp;
    int         i;
    wr(ADDR_STATUS, base);
    exp = base;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i       <= '{code: c, bit_sel: 3'h0, reg_idx: 5'h00};
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      if (i < 7)
        op_i <= '{code: c, bit_sel: 3'(i + 1), reg_idx: 5'h00};
      else
        op_valid_i <= 1'b0;
      exp[i] = (c == OP_INDEXED_FLAG_RAISE);
      @(negedge clk_i);
      cmp({24'h0, status_flags_o}, {24'h0, exp}, "indexed op");
    end
  endtask

  task automatic t_bit_store;
    wr(ADDR_REG_BASE + 8'h14, 8'h40);
    wr(ADDR_STATUS, 8'h00);
    do_op(OP_BIT_TO_TRANSFER_FLAG, 3'h6, 5'h05);
    cmp({24'h0, status_flags_o}, 32'h40, "store one");
    wr(ADDR_STATUS, 8'hFF);
    do_op(OP_BIT_TO_TRANSFER_FLAG, 3'h0, 5'h05);
    cmp({24'h0, status_flags_o}, 32'hBF, "store zero");
  endtask

  task automatic t_bit_load;
    wr(ADDR_REG_BASE + 8'h24, 8'h00);
    wr(ADDR_STATUS, 8'h40);
    do_op(OP_TRANSFER_FLAG_TO_BIT, 3'h7, 5'h09);
    cmp({24'h0, status_flags_o}, 32'h40, "load keeps flags");
    wb_xfer(1'b0, ADDR_REG_BASE + 8'h24, 32'h0, 4'hF, rd);
    cmp(rd, 32'h80, "load one");
    wr(ADDR_REG_BASE + 8'h24, 8'hFF);
    wr(ADDR_STATUS, 8'hBF);
    do_op(OP_TRANSFER_FLAG_TO_BIT, 3'h0, 5'h09);
    cmp({24'h0, status_flags_o}, 32'hBF, "load keeps flags");
    wb_xfer(1'b0, ADDR_REG_BASE + 8'h24, 32'h0, 4'hF, rd);
    cmp(rd, 32'hFE, "load zero");
  endtask

  // Unknown codes only pulse done and leave every flag alone
  task automatic t_refused;
    wr(ADDR_STATUS, 8'h5A);
    wb_xfer(1'b0, ADDR_STATUS, 32'h0, 4'hF, rd);
    cmp(rd, 32'h5A, "status read");
    do_op(OP_NONE, 3'h2, 5'h00);
    cmp({24'h0, status_flags_o}, 32'h5A, "no-op keeps flags");
    do_op(op_e'(5'h1F), 3'h5, 5'h00);
    cmp({24'h0, status_flags_o}, 32'h5A, "unknown code keeps flags");
  endtask

  // Bus command path must behave like the decoder port
  task automatic t_command;
    wr(ADDR_STATUS, 8'h00);
    wb_xfer(1'b1, ADDR_COMMAND, {11'h0, 5'h00, 5'h0, 3'h3, 3'h0, OP_INDEXED_FLAG_RAISE}, 4'hF, rd);
    @(negedge clk_i);
    @(negedge clk_i);
    cmp({24'h0, status_flags_o}, 32'h08, "bus raise");
    wb_xfer(1'b0, ADDR_COMMAND, 32'h0, 4'hF, rd);
    cmp(rd, 32'h0, "command reads zero");
  endtask

  // ****************************************************************************
  // Sequence, watchdog and verdict
  // ****************************************************************************
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    n_mismatch = 0;
    checks     = 0;
    rst_i      = 1'b1;
    op_valid_i = 1'b0;
    op_i       = '0;
    wb_i       = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    t_reset();
    t_flag_ops();
    t_indexed(OP_INDEXED_FLAG_CLEAR, 8'hFF);
    t_indexed(OP_INDEXED_FLAG_RAISE, 8'h00);
    t_bit_store();
    t_bit_load();
    t_refused();
    t_command();
    tally_and_finish();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
